// file: rtl/tca_pkg.sv
// Shared constants for the temperature conversion and alarm link
`default_nettype none
package tca_pkg;
  // Command codes
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_COPY = 8'h48;
  localparam logic [7:0] CMD_RECALL = 8'hb8;
  localparam logic [7:0] CMD_SKIP = 8'hcc;
  localparam logic [7:0] CMD_PWR = 8'hb4;
  localparam logic [7:0] CMD_SEARCH = 8'hec;
  // Scratchpad byte positions
  localparam logic [3:0] SP_TEMP_LO = 4'h0;
  localparam logic [3:0] SP_TEMP_HI = 4'h1;
  localparam logic [3:0] SP_TH = 4'h2;
  localparam logic [3:0] SP_TL = 4'h3;
  localparam logic [3:0] SP_REMAIN = 4'h6;
  localparam logic [3:0] SP_CPD = 4'h7;
  localparam logic [3:0] SP_LAST = 4'h7;
  localparam logic [7:0] SP_RSVD_VAL = 8'hff;
  // Values after reset
  localparam logic [15:0] TEMP_RST = 16'h00aa;
  localparam logic [7:0] COUNTS_PER_DEGREE = 8'h10;
  localparam logic [7:0] TH_NV_RST = 8'h7f;
  localparam logic [7:0] TL_NV_RST = 8'h80;
  // Fine result offset of 0.25 degree in sixteenths
  localparam logic [15:0] QUARTER_SIXTEENTHS = 16'h0004;
  // Timing
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned CONV_TIME_MS = 800;
  localparam int unsigned WR_TIME_MS = 10;
  localparam int unsigned CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
  localparam int unsigned WR_CYCLES = WR_TIME_MS * CLK_KHZ;
  // Master operations
  localparam logic [2:0] OP_CONVERT = 3'h0;
  localparam logic [2:0] OP_QUERY = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_COPY = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_SEARCH = 3'h5;
  localparam logic [2:0] OP_RECALL = 3'h6;
  // What the next read slot reports
  localparam logic [1:0] SLOT_NONE = 2'h0;
  localparam logic [1:0] SLOT_CONV = 2'h1;
  localparam logic [1:0] SLOT_PWR = 2'h2;
  localparam logic [1:0] SLOT_SRCH = 2'h3;
endpackage
`default_nettype wire

// file: rtl/tca_link_if.sv
// Command and slot level link between bus master and thermometer
`timescale 1ns/1ps
`default_nettype none
interface tca_link_if;
  logic cmd_stb;
  logic [7:0] cmd_code;
  logic slot_stb;
  logic slot_ack;
  logic slot_bit;
  logic wr_stb;
  logic rd_stb;
  logic [3:0] sp_idx;
  logic [7:0] wr_data;
  logic rd_ack;
  logic [7:0] rd_data;
  modport dev (
    input cmd_stb, cmd_code, slot_stb, wr_stb, rd_stb, sp_idx, wr_data,
    output slot_ack, slot_bit, rd_ack, rd_data
  );
  modport mst (
    output cmd_stb, cmd_code, slot_stb, wr_stb, rd_stb, sp_idx, wr_data,
    input slot_ack, slot_bit, rd_ack, rd_data
  );
endinterface
`default_nettype wire

// file: rtl/tca_dev.sv
// Thermometer end: conversion, result format, alarm and supply reporting
`timescale 1ns/1ps
`default_nettype none
module tca_dev #(
  parameter int unsigned CONV_CYCLES = tca_pkg::CONV_CYCLES,
  parameter int unsigned WR_CYCLES = tca_pkg::WR_CYCLES
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Link to the bus master
  tca_link_if.dev LNK,
  // Sensor and supply
  input wire logic EXT_SUPPLY_INPUT,
  input wire logic [8:0] SENSOR_CODE,
  input wire logic [7:0] SENSOR_REMAIN,
  // Status
  output logic CONV_ACTIVE,
  output logic ALARM_FLAG,
  output logic PARASITE_MODE,
  output logic [15:0] TEMP_RESULT
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_COPY = 3'b100
  } tca_dst_t;

  typedef struct packed {
    tca_dst_t st;
    logic [31:0] cnt;
    logic [15:0] temp;
    logic [7:0] remain;
    logic [7:0] th;
    logic [7:0] tl;
    logic [7:0] th_nv;
    logic [7:0] tl_nv;
    logic alarm;
    logic ext;
    logic skip_seen;
    logic [1:0] slot_mode;
    logic slot_ack;
    logic slot_bit;
    logic rd_ack;
    logic [7:0] rd_data;
  } tca_dev_s_t;

  tca_dev_s_t cur_ff;
  tca_dev_s_t nxt_ff;

  // Alarm test on the whole-degree part against both signed thresholds
  function automatic logic alarm_test(input logic [15:0] t, input logic [7:0] hi,
                                      input logic [7:0] lo);
    logic signed [7:0] v;
    v = signed'(t[8:1]);
    alarm_test = (v <= signed'(lo)) || (v > signed'(hi));
  endfunction

  // Scratchpad byte view
  function automatic logic [7:0] sp_byte(input tca_dev_s_t s, input logic [3:0] idx);
    case (idx)
      tca_pkg::SP_TEMP_LO: sp_byte = s.temp[7:0];
      tca_pkg::SP_TEMP_HI: sp_byte = s.temp[15:8];
      tca_pkg::SP_TH: sp_byte = s.th;
      tca_pkg::SP_TL: sp_byte = s.tl;
      tca_pkg::SP_REMAIN: sp_byte = s.remain;
      tca_pkg::SP_CPD: sp_byte = tca_pkg::COUNTS_PER_DEGREE;
      default: sp_byte = tca_pkg::SP_RSVD_VAL;
    endcase
  endfunction

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.slot_ack = 1'b0;
    nxt_ff.rd_ack = 1'b0;
    nxt_ff.ext = EXT_SUPPLY_INPUT;

    // Read slot answer, chosen by the last function command
    if (LNK.slot_stb) begin
      nxt_ff.slot_ack = 1'b1;
      case (cur_ff.slot_mode)
        tca_pkg::SLOT_CONV: nxt_ff.slot_bit = !cur_ff.ext || (cur_ff.st != ST_CONV);
        tca_pkg::SLOT_PWR: nxt_ff.slot_bit = cur_ff.ext;
        tca_pkg::SLOT_SRCH: nxt_ff.slot_bit = !cur_ff.alarm;
        default: nxt_ff.slot_bit = 1'b1;
      endcase
    end

    // Scratchpad access; only threshold bytes are writable
    if (LNK.rd_stb) begin
      nxt_ff.rd_ack = 1'b1;
      nxt_ff.rd_data = sp_byte(cur_ff, LNK.sp_idx);
    end
    if (LNK.wr_stb) begin
      if (LNK.sp_idx == tca_pkg::SP_TH) begin
        nxt_ff.th = LNK.wr_data;
      end
      if (LNK.sp_idx == tca_pkg::SP_TL) begin
        nxt_ff.tl = LNK.wr_data;
      end
    end

    // Function commands
    if (LNK.cmd_stb) begin
      nxt_ff.skip_seen = 1'b0;
      nxt_ff.slot_mode = tca_pkg::SLOT_NONE;
      case (LNK.cmd_code)
        tca_pkg::CMD_CONVERT: begin
          nxt_ff.slot_mode = tca_pkg::SLOT_CONV;
          if (cur_ff.st == ST_IDLE) begin
            nxt_ff.st = ST_CONV;
            nxt_ff.cnt = 32'(CONV_CYCLES - 1);
          end
        end
        tca_pkg::CMD_COPY: begin
          if (cur_ff.st == ST_IDLE) begin
            nxt_ff.st = ST_COPY;
            nxt_ff.cnt = 32'(WR_CYCLES - 1);
          end
        end
        tca_pkg::CMD_RECALL: begin
          nxt_ff.th = cur_ff.th_nv;
          nxt_ff.tl = cur_ff.tl_nv;
        end
        tca_pkg::CMD_SKIP: nxt_ff.skip_seen = 1'b1;
        tca_pkg::CMD_PWR: begin
          if (cur_ff.skip_seen) begin
            nxt_ff.slot_mode = tca_pkg::SLOT_PWR;
          end
        end
        tca_pkg::CMD_SEARCH: nxt_ff.slot_mode = tca_pkg::SLOT_SRCH;
        default: nxt_ff.slot_mode = tca_pkg::SLOT_NONE;
      endcase
    end

    // Internal timing of conversion and nonvolatile copy
    case (cur_ff.st)
      ST_IDLE: ;
      ST_CONV: begin
        if (cur_ff.cnt == 32'h0) begin
          nxt_ff.temp = {{7{SENSOR_CODE[8]}}, SENSOR_CODE};
          nxt_ff.remain = SENSOR_REMAIN;
          nxt_ff.alarm = alarm_test(nxt_ff.temp, cur_ff.th, cur_ff.tl);
          nxt_ff.st = ST_IDLE;
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 32'h1;
        end
      end
      ST_COPY: begin
        if (cur_ff.cnt == 32'h0) begin
          nxt_ff.th_nv = cur_ff.th;
          nxt_ff.tl_nv = cur_ff.tl;
          nxt_ff.st = ST_IDLE;
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 32'h1;
        end
      end
      default: nxt_ff.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cur_ff.st <= ST_IDLE;
      cur_ff.cnt <= 32'h0;
      cur_ff.temp <= tca_pkg::TEMP_RST;
      cur_ff.remain <= 8'h00;
      cur_ff.th <= tca_pkg::TH_NV_RST;
      cur_ff.tl <= tca_pkg::TL_NV_RST;
      cur_ff.th_nv <= tca_pkg::TH_NV_RST;
      cur_ff.tl_nv <= tca_pkg::TL_NV_RST;
      cur_ff.alarm <= 1'b0;
      cur_ff.ext <= 1'b0;
      cur_ff.skip_seen <= 1'b0;
      cur_ff.slot_mode <= tca_pkg::SLOT_NONE;
      cur_ff.slot_ack <= 1'b0;
      cur_ff.slot_bit <= 1'b1;
      cur_ff.rd_ack <= 1'b0;
      cur_ff.rd_data <= 8'h00;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign LNK.slot_ack = cur_ff.slot_ack;
  assign LNK.slot_bit = cur_ff.slot_bit;
  assign LNK.rd_ack = cur_ff.rd_ack;
  assign LNK.rd_data = cur_ff.rd_data;
  assign CONV_ACTIVE = (cur_ff.st == ST_CONV);
  assign ALARM_FLAG = cur_ff.alarm;
  assign PARASITE_MODE = !cur_ff.ext;
  assign TEMP_RESULT = cur_ff.temp;

endmodule
`default_nettype wire

// file: rtl/tca_mst.sv
// Bus master end: command sequencing, strong pullup, fine result
`timescale 1ns/1ps
`default_nettype none
module tca_mst #(
  parameter int unsigned CONV_CYCLES = tca_pkg::CONV_CYCLES,
  parameter int unsigned WR_CYCLES = tca_pkg::WR_CYCLES
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Link to the thermometer
  tca_link_if.mst LNK,
  // User requests
  input wire logic USR_STB,
  input wire logic [2:0] USR_OP,
  input wire logic [7:0] USR_TH,
  input wire logic [7:0] USR_TL,
  // Status and results
  output logic USR_BUSY,
  output logic USR_DONE,
  output logic SPU_EN,
  output logic PARASITE_SEEN,
  output logic ALARM_SEEN,
  output logic ALARM_STALE,
  output logic [15:0] TEMP_RAW,
  output logic [15:0] FINE_TEMP
);

  typedef enum logic [8:0] {
    M_IDLE = 9'b000000001,
    M_CMD = 9'b000000010,
    M_SLOT = 9'b000000100,
    M_SACK = 9'b000001000,
    M_WAIT = 9'b000010000,
    M_WR = 9'b000100000,
    M_RD = 9'b001000000,
    M_RACK = 9'b010000000,
    M_DONE = 9'b100000000
  } tca_mst_t;

  typedef struct packed {
    tca_mst_t st;
    logic [2:0] op;
    logic [3:0] idx;
    logic [31:0] cnt;
    logic [7:0] th;
    logic [7:0] tl;
    logic [7:0][7:0] sp;
    logic parasite;
    logic alarm;
    logic stale;
    logic [15:0] fine;
  } tca_mst_s_t;

  tca_mst_s_t cur_ff;
  tca_mst_s_t nxt_ff;

  function automatic logic [7:0] cmd_of(input logic [2:0] op, input logic [3:0] idx);
    case (op)
      tca_pkg::OP_CONVERT: cmd_of = tca_pkg::CMD_CONVERT;
      tca_pkg::OP_COPY: cmd_of = tca_pkg::CMD_COPY;
      tca_pkg::OP_RECALL: cmd_of = tca_pkg::CMD_RECALL;
      tca_pkg::OP_SEARCH: cmd_of = tca_pkg::CMD_SEARCH;
      tca_pkg::OP_QUERY: cmd_of = (idx == 4'h0) ? tca_pkg::CMD_SKIP : tca_pkg::CMD_PWR;
      default: cmd_of = tca_pkg::CMD_SKIP;
    endcase
  endfunction

  always_comb begin
    logic [15:0] whole;
    whole = {{2{cur_ff.sp[1][7]}}, cur_ff.sp[1][6:0], cur_ff.sp[0][7:1]};
    nxt_ff = cur_ff;
    case (cur_ff.st)
      M_IDLE: begin
        if (USR_STB) begin
          nxt_ff.op = USR_OP;
          nxt_ff.th = USR_TH;
          nxt_ff.tl = USR_TL;
          nxt_ff.idx = 4'h0;
          if (USR_OP == tca_pkg::OP_WRITE) begin
            nxt_ff.idx = tca_pkg::SP_TH;
            nxt_ff.st = M_WR;
          end else if (USR_OP == tca_pkg::OP_READ) begin
            nxt_ff.st = M_RD;
          end else begin
            nxt_ff.st = M_CMD;
          end
        end
      end
      M_CMD: begin
        nxt_ff.idx = 4'h0;
        if (cur_ff.op == tca_pkg::OP_QUERY && cur_ff.idx == 4'h0) begin
          nxt_ff.idx = 4'h1;
        end else if (cur_ff.op == tca_pkg::OP_CONVERT && cur_ff.parasite) begin
          nxt_ff.cnt = 32'(CONV_CYCLES - 1);
          nxt_ff.st = M_WAIT;
        end else if (cur_ff.op == tca_pkg::OP_COPY) begin
          nxt_ff.cnt = 32'(WR_CYCLES - 1);
          nxt_ff.st = M_WAIT;
        end else if (cur_ff.op == tca_pkg::OP_RECALL) begin
          nxt_ff.st = M_DONE;
        end else begin
          nxt_ff.st = M_SLOT;
        end
      end
      M_SLOT: nxt_ff.st = M_SACK;
      M_SACK: begin
        if (LNK.slot_ack) begin
          nxt_ff.st = M_DONE;
          case (cur_ff.op)
            tca_pkg::OP_QUERY: nxt_ff.parasite = !LNK.slot_bit;
            tca_pkg::OP_SEARCH: nxt_ff.alarm = !LNK.slot_bit;
            default: begin
              if (LNK.slot_bit) begin
                nxt_ff.stale = 1'b0;
              end else begin
                nxt_ff.st = M_SLOT;
              end
            end
          endcase
        end
      end
      M_WAIT: begin
        if (cur_ff.cnt == 32'h0) begin
          if (cur_ff.op == tca_pkg::OP_CONVERT) begin
            nxt_ff.stale = 1'b0;
          end
          nxt_ff.st = M_DONE;
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 32'h1;
        end
      end
      M_WR: begin
        nxt_ff.stale = 1'b1;
        nxt_ff.idx = tca_pkg::SP_TL;
        if (cur_ff.idx == tca_pkg::SP_TL) begin
          nxt_ff.st = M_DONE;
        end
      end
      M_RD: nxt_ff.st = M_RACK;
      M_RACK: begin
        if (LNK.rd_ack) begin
          nxt_ff.sp[cur_ff.idx[2:0]] = LNK.rd_data;
          nxt_ff.idx = cur_ff.idx + 4'h1;
          nxt_ff.st = (cur_ff.idx == tca_pkg::SP_LAST) ? M_DONE : M_RD;
        end
      end
      M_DONE: nxt_ff.st = M_IDLE;
      default: nxt_ff.st = M_IDLE;
    endcase
    if (cur_ff.st == M_DONE && cur_ff.op == tca_pkg::OP_READ) begin
      nxt_ff.fine = 16'((whole << 4) - tca_pkg::QUARTER_SIXTEENTHS
                    + {8'h00, cur_ff.sp[7]} - {8'h00, cur_ff.sp[6]});
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cur_ff <= '0;
      cur_ff.st <= M_IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Only one strobe is active per state, so traffic never overlaps the pullup
  assign LNK.cmd_stb = (cur_ff.st == M_CMD);
  assign LNK.cmd_code = cmd_of(cur_ff.op, cur_ff.idx);
  assign LNK.slot_stb = (cur_ff.st == M_SLOT);
  assign LNK.wr_stb = (cur_ff.st == M_WR);
  assign LNK.rd_stb = (cur_ff.st == M_RD);
  assign LNK.sp_idx = cur_ff.idx;
  assign LNK.wr_data = (cur_ff.idx == tca_pkg::SP_TH) ? cur_ff.th : cur_ff.tl;
  assign SPU_EN = (cur_ff.st == M_WAIT) && cur_ff.parasite;
  assign USR_BUSY = (cur_ff.st != M_IDLE);
  assign USR_DONE = (cur_ff.st == M_DONE);
  assign PARASITE_SEEN = cur_ff.parasite;
  assign ALARM_SEEN = cur_ff.alarm;
  assign ALARM_STALE = cur_ff.stale;
  assign TEMP_RAW = {cur_ff.sp[1], cur_ff.sp[0]};
  assign FINE_TEMP = cur_ff.fine;

endmodule
`default_nettype wire

// file: tb/tca_link_sva.sv
// Link checker for the thermometer and bus master ends
`timescale 1ns/1ps
`default_nettype none
module tca_link_sva (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Link signals
  input wire logic cmd_stb,
  input wire logic [7:0] cmd_code,
  input wire logic slot_stb,
  input wire logic slot_ack,
  input wire logic slot_bit,
  input wire logic rd_stb,
  input wire logic [3:0] sp_idx,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  // Thermometer status
  input wire logic CONV_ACTIVE,
  input wire logic ALARM_FLAG,
  input wire logic PARASITE_MODE,
  input wire logic [15:0] TEMP_RESULT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // Supply query: skip, power read, then one slot
  sequence s_query;
    cmd_stb && cmd_code == 8'hcc ##[1:3] cmd_stb && cmd_code == 8'hb4 ##[1:3] slot_stb;
  endsequence
  sequence s_search;
    cmd_stb && cmd_code == 8'hec ##[1:3] slot_stb;
  endsequence
  a_slot_ack_next: assert property (slot_stb |=> slot_ack && !$past(slot_ack))
    else $error("slot answer not one cycle after request");
  a_rd_ack_next: assert property (rd_stb |=> rd_ack)
    else $error("read answer not one cycle after request");
  a_conv_start: assert property (cmd_stb && cmd_code == 8'h44 && !CONV_ACTIVE |=> CONV_ACTIVE)
    else $error("conversion did not start on convert command");
  a_conv_cause: assert property ($rose(CONV_ACTIVE) |-> $past(cmd_stb && cmd_code == 8'h44))
    else $error("conversion started without convert command");
  a_temp_sign: assert property (TEMP_RESULT[15:8] == {8{TEMP_RESULT[8]}})
    else $error("temperature upper byte is not sign copies");
  a_temp_at_end: assert property (!$stable(TEMP_RESULT) |-> $fell(CONV_ACTIVE))
    else $error("temperature changed outside conversion end");
  a_alarm_at_end: assert property ($changed(ALARM_FLAG) |-> $fell(CONV_ACTIVE))
    else $error("alarm flag changed outside conversion end");
  a_busy_bit_low: assert property (slot_stb && CONV_ACTIVE && !PARASITE_MODE |=> !slot_bit)
    else $error("busy slot not answered with zero");
  a_power_answer: assert property (s_query |=> slot_ack && slot_bit == !PARASITE_MODE)
    else $error("power query answer does not match supply mode");
  a_search_answer: assert property (s_search |=> slot_bit == !ALARM_FLAG)
    else $error("alarm search answer does not match alarm flag");
  a_cpd_fixed: assert property (rd_stb && sp_idx == 4'h7 |=> rd_data == 8'h10)
    else $error("counts per degree byte is not sixteen");
endmodule
`default_nettype wire

// file: tb/test_temp_convert_alarm_logic.sv
// Bench for both link ends with random and corner conversions
`timescale 1ns/1ps
`default_nettype none
`define TCA_CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_temp_convert_alarm_logic;
  localparam int unsigned CONV = 20;
  localparam int unsigned WR = 10;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic ext = 1'b1;
  logic [8:0] code = 9'h0;
  logic [7:0] remain = 8'h0;
  logic stb = 1'b0;
  logic [2:0] op = 3'h0;
  logic [7:0] th = 8'h7f;
  logic [7:0] tl = 8'h80;
  logic conv_act, alarm, parasite, busy, done, spu, par_seen, al_seen, stale;
  logic [15:0] temp, raw, fine;
  logic [7:0] sp [0:7];
  logic [3:0] last_idx = 4'h0;
  int miscompares = 0;
  int n_tests = 0;
  int spu_n = 0;
  int spu_bad = 0;
  int conv_n = 0;
  int slot_n = 0;
  tca_link_if lnk ();
  tca_dev #(.CONV_CYCLES(CONV), .WR_CYCLES(WR)) u_tca_dev (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .LNK(lnk), .EXT_SUPPLY_INPUT(ext), .SENSOR_CODE(code), .SENSOR_REMAIN(remain),
    .CONV_ACTIVE(conv_act), .ALARM_FLAG(alarm), .PARASITE_MODE(parasite), .TEMP_RESULT(temp));
  tca_mst #(.CONV_CYCLES(CONV), .WR_CYCLES(WR)) u_tca_mst (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .LNK(lnk), .USR_STB(stb), .USR_OP(op), .USR_TH(th), .USR_TL(tl), .USR_BUSY(busy),
    .USR_DONE(done), .SPU_EN(spu), .PARASITE_SEEN(par_seen), .ALARM_SEEN(al_seen),
    .ALARM_STALE(stale), .TEMP_RAW(raw), .FINE_TEMP(fine));
  tca_link_sva u_tca_link_sva (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .cmd_stb(lnk.cmd_stb),
    .cmd_code(lnk.cmd_code), .slot_stb(lnk.slot_stb), .slot_ack(lnk.slot_ack),
    .slot_bit(lnk.slot_bit), .rd_stb(lnk.rd_stb), .sp_idx(lnk.sp_idx), .rd_ack(lnk.rd_ack),
    .rd_data(lnk.rd_data), .CONV_ACTIVE(conv_act), .ALARM_FLAG(alarm),
    .PARASITE_MODE(parasite), .TEMP_RESULT(temp));
  always #4 CLK_SYS = ~CLK_SYS;
  // Scratchpad bytes as they cross the link, and pullup traffic watch
  always @(posedge CLK_SYS) begin
    if (lnk.rd_stb === 1'b1) last_idx <= lnk.sp_idx;
    if (lnk.rd_ack === 1'b1) sp[last_idx[2:0]] <= lnk.rd_data;
    if (spu === 1'b1) spu_n++;
    if (conv_act === 1'b1) conv_n++;
    if (lnk.slot_stb === 1'b1) slot_n++;
    if (spu === 1'b1 && (lnk.cmd_stb | lnk.slot_stb | lnk.rd_stb | lnk.wr_stb) !== 1'b0) spu_bad++;
  end
  function automatic logic [15:0] fine_exp(input logic [15:0] t, input logic [7:0] r);
    logic [15:0] rd;
    rd = {t[15], t[15:1]};
    return (rd << 4) - 16'h0004 + 16'h0010 - {8'h00, r};
  endfunction
  function automatic logic alarm_exp(input logic [8:0] c, input logic [7:0] h, input logic [7:0] l);
    return ($signed(c[8:1]) <= $signed(l)) || ($signed(c[8:1]) > $signed(h));
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic run_op(input logic [2:0] opc);
    int k;
    spu_n = 0;
    spu_bad = 0;
    conv_n = 0;
    slot_n = 0;
    op = opc;
    stb = 1'b1;
    @(posedge CLK_SYS);
    #1;
    stb = 1'b0;
    `TCA_CHK("busy", 1'b1, busy)
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge CLK_SYS);
      #1;
    end
    `TCA_CHK("done", 1'b1, done)
    @(posedge CLK_SYS);
    #1;
    `TCA_CHK("pullup traffic", 0, spu_bad)
    `TCA_CHK("busy after done", 1'b0, busy)
  endtask
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
  initial begin
    logic exp_al;
    logic [7:0] cth;
    void'($urandom(32'h55b4));
    repeat (10) @(posedge CLK_SYS);
    #1;
    RST_B = 1'b1;
    `TCA_CHK("temp reset", 16'h00aa, temp)
    `TCA_CHK("idle", 1'b0, conv_act)
    for (int i = 0; i < 14; i++) begin
      ext = (i < 3) ? 1'b1 : 1'(($urandom % 2));
      th = (i < 3) ? 8'h19 : 8'($urandom);
      tl = (i < 3) ? 8'hf0 : 8'($urandom);
      code = (i == 0) ? {8'hf0, 1'b0} : (i == 1) ? {8'h19, 1'b1} : (i == 2) ? {8'h1a, 1'b0} :
        9'($urandom);
      remain = 8'($urandom_range(0, 16));
      run_op(3'h1);
      `TCA_CHK("parasite seen", ~ext, par_seen)
      `TCA_CHK("parasite mode", ~ext, parasite)
      run_op(3'h2);
      `TCA_CHK("stale set", 1'b1, stale)
      run_op(3'h0);
      `TCA_CHK("stale clear", 1'b0, stale)
      `TCA_CHK("conversion length", int'(CONV), conv_n)
      `TCA_CHK("poll slots", ext ? int'(CONV / 2 + 1) : 0, slot_n)
      `TCA_CHK("idle after conversion", 1'b0, conv_act)
      `TCA_CHK("pullup length", ext ? 0 : int'(CONV), spu_n)
      `TCA_CHK("temp", {{7{code[8]}}, code}, temp)
      exp_al = alarm_exp(code, th, tl);
      `TCA_CHK("alarm", exp_al, alarm)
      run_op(3'h4);
      `TCA_CHK("raw", {{7{code[8]}}, code}, raw)
      `TCA_CHK("fine", fine_exp({{7{code[8]}}, code}, remain), fine)
      `TCA_CHK("byte2", th, sp[2])
      `TCA_CHK("byte3", tl, sp[3])
      `TCA_CHK("byte4", 8'hff, sp[4])
      `TCA_CHK("byte6", remain, sp[6])
      `TCA_CHK("byte7", 8'h10, sp[7])
      run_op(3'h5);
      `TCA_CHK("alarm seen", exp_al, al_seen)
    end
    // Copy, overwrite, then recall restores the stored thresholds
    cth = th;
    run_op(3'h3);
    `TCA_CHK("copy pullup", ext ? 0 : int'(WR), spu_n)
    th = ~cth;
    run_op(3'h2);
    run_op(3'h6);
    run_op(3'h4);
    `TCA_CHK("recalled byte2", cth, sp[2])
    RST_B = 1'b0;
    #1;
    `TCA_CHK("temp mid reset", 16'h00aa, temp)
    repeat (3) @(posedge CLK_SYS);
    #1;
    RST_B = 1'b1;
    `TCA_CHK("alarm reset", 1'b0, alarm)
    `TCA_CHK("temp after reset", 16'h00aa, temp)
    // First request right after release, then a conversion with reset thresholds
    run_op(3'h1);
    `TCA_CHK("parasite after reset", ~ext, par_seen)
    run_op(3'h0);
    `TCA_CHK("temp after reset conversion", {{7{code[8]}}, code}, temp)
    `TCA_CHK("alarm after reset", alarm_exp(code, 8'h7f, 8'h80), alarm)
    end_of_test();
  end
endmodule
`default_nettype wire
